// File: bench/cdc_cfg_host.sv
// host model: drives register and nvram strobes of the serial interface
// assumes the bench calls its tasks; signals move 1 ns after the edge
`timescale 1ns/100ps
module cdc_cfg_host (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_granted,
  input wire logic i_blocked,
  output logic o_wr,
  output logic o_rd,
  output logic [5:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_nv_req,
  output logic [9:0] o_nv_addr
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 6'h00;
    o_wdata = 8'h00;
    o_nv_req = 1'b0;
    o_nv_addr = 10'h000;
  end

  // the trim byte is device specific, so the host never writes it
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_wr = (a != 6'h3e);
    o_addr = a;
    o_wdata = d;
    @(posedge i_sys_clk);
    #1;
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] q);
    @(posedge i_sys_clk);
    #1;
    o_rd = 1'b1;
    o_addr = a;
    @(posedge i_sys_clk);
    #1;
    o_rd = 1'b0;
    o_addr = ~a;
    q = i_rdata;
  endtask

  task automatic nv(input logic [9:0] a, output logic g, output logic b);
    @(posedge i_sys_clk);
    #1;
    o_nv_req = 1'b1;
    o_nv_addr = a;
    @(posedge i_sys_clk);
    #1;
    o_nv_req = 1'b0;
    o_nv_addr = ~a;
    g = i_granted;
    b = i_blocked;
  endtask
endmodule

// File: bench/cdc_config_regs_upper_properties.sv
// assertions on the ports of the upper configuration bank
// assumes one clock domain and the asynchronous active-low reset
`timescale 1ns/100ps
module cdc_config_regs_upper_properties (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_nv_req,
  input wire logic [9:0] i_nv_addr,
  input wire logic o_nv_granted,
  input wire logic o_nv_blocked,
  input wire logic o_nv_store_en,
  input wire logic o_nv_recall_en,
  input wire logic o_nv_erase_en,
  input wire logic [7:0] o_cap_ratio_sel,
  input wire logic [7:0] o_res_ratio_sel,
  input wire logic o_alarm_source_choice,
  input wire logic o_hold_until_read,
  input wire logic o_median_res_en,
  input wire logic o_median_cap_en,
  input wire logic o_run_enable,
  input wire logic o_protect
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic any_cmd;
  assign any_cmd = o_nv_store_en | o_nv_recall_en | o_nv_erase_en;

  chk_run_protect: assert property (
    o_protect != o_run_enable) else $error("protect not inverse of run");
  chk_run_write: assert property (
    i_reg_wr && i_reg_addr == 6'h2f |=> o_run_enable == $past(i_reg_wdata[0]))
    else $error("run bit not taken from write");
  chk_cap_write: assert property (
    i_reg_wr && i_reg_addr == 6'h28 |=> o_cap_ratio_sel == $past(i_reg_wdata))
    else $error("cap ratio selector not stored");
  chk_res_write: assert property (
    i_reg_wr && i_reg_addr == 6'h29 |=> o_res_ratio_sel == $past(i_reg_wdata))
    else $error("res ratio selector not stored");
  chk_flag_write: assert property (
    i_reg_wr && i_reg_addr == 6'h2a |=> {o_alarm_source_choice,
    o_hold_until_read, o_median_res_en, o_median_cap_en} == $past(
    {i_reg_wdata[6], i_reg_wdata[3], i_reg_wdata[1:0]}))
    else $error("feature flags not stored");
  chk_cmd_erase: assert property (
    i_reg_wr && i_reg_addr == 6'h36 && i_reg_wdata == 8'hb8
    |=> o_nv_erase_en && !o_nv_store_en && !o_nv_recall_en)
    else $error("erase code not decoded");
  chk_cmd_clear: assert property (
    any_cmd && (i_reg_rd || i_nv_req || i_reg_wr)
    && !(i_reg_wr && i_reg_addr == 6'h36) |=> !any_cmd)
    else $error("memory command not cleared by activity");
  chk_nv_answer: assert property (
    i_nv_req |=> o_nv_granted != o_nv_blocked)
    else $error("nvram request not answered once");
  chk_nv_gap: assert property (
    i_nv_req && i_nv_addr inside {[10'h3f0:10'h3fd]} |=> o_nv_granted)
    else $error("unlockable nvram range was blocked");
  chk_nv_quiet: assert property (
    !i_nv_req |=> !o_nv_granted && !o_nv_blocked)
    else $error("nvram answer without request");
endmodule

bind cdc_config_regs_upper cdc_config_regs_upper_properties u_props (
  .i_sys_clk, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
  .i_nv_req, .i_nv_addr, .o_nv_granted, .o_nv_blocked, .o_nv_store_en,
  .o_nv_recall_en, .o_nv_erase_en, .o_cap_ratio_sel, .o_res_ratio_sel,
  .o_alarm_source_choice, .o_hold_until_read, .o_median_res_en,
  .o_median_cap_en, .o_run_enable, .o_protect);

// File: bench/cdc_config_regs_upper_tb.sv
// self-checking bench for the upper configuration bank
// assumes the host model owns the register and nvram request strobes
`timescale 1ns/100ps
module cdc_config_regs_upper_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr, rd, nv_req, g, b, erase_done, res_rd, st, rc, er, run, prot;
  logic ng, nb, pol;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, cap, res, trim, q, res_valid;
  logic [9:0] nv_addr;
  logic [2:0] res_idx;
  logic [7:0][31:0] res_word;
  logic [31:0] res_rdata, if0, if1;
  logic [3:0] flags;
  logic [9:0] nva [12] = '{10'h000, 10'h2bf, 10'h2c0, 10'h33f, 10'h340,
    10'h3bf, 10'h3c0, 10'h3ef, 10'h3f0, 10'h3fd, 10'h3fe, 10'h3ff};
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int r;

  always #50 clk = ~clk;

  cdc_config_regs_upper #(.PUMP_TRIM_RESET(8'h3c)) u_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_nv_req(nv_req), .i_nv_addr(nv_addr), .o_nv_granted(g),
    .o_nv_blocked(b), .i_nv_erase_done(erase_done), .o_nv_store_en(st),
    .o_nv_recall_en(rc), .o_nv_erase_en(er), .i_res_valid(res_valid),
    .i_res_word(res_word), .i_res_rd(res_rd), .i_res_idx(res_idx),
    .o_res_rdata(res_rdata), .o_pulse_if0_word(if0),
    .o_pulse_if1_word(if1), .o_cap_ratio_sel(cap), .o_res_ratio_sel(res),
    .o_alarm_source_choice(flags[3]), .o_alarm_polarity_choice(pol),
    .o_hold_until_read(flags[2]), .o_median_res_en(flags[1]),
    .o_median_cap_en(flags[0]), .o_run_enable(run), .o_protect(prot),
    .o_pump_trim(trim));

  cdc_cfg_host u_host (.i_sys_clk(clk), .i_rdata(rdata), .i_granted(g),
    .i_blocked(b), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
    .o_nv_req(nv_req), .o_nv_addr(nv_addr));

  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk_reg(input logic [5:0] a, input logic [7:0] exp);
    u_host.rd(a, q);
    check($sformatf("reg %h", a), {24'h0, q}, {24'h0, exp});
  endtask

  task automatic offer(input int k, input logic [31:0] v);
    @(posedge clk);
    #1;
    res_word[k] = v;
    res_valid[k] = 1'b1;
    @(posedge clk);
    #1;
    res_valid = 8'h00;
    res_word[k] = ~v;
  endtask

  task automatic rres(input int k, input logic [31:0] exp);
    @(posedge clk);
    #1;
    res_rd = 1'b1;
    res_idx = k[2:0];
    @(posedge clk);
    #1;
    res_rd = 1'b0;
    check("result", res_rdata, exp);
  endtask

  // nvram lock range index of an address; 4 means never lockable
  function automatic int range_of(input logic [9:0] a);
    if (a <= 10'h2bf) return 0;
    if (a <= 10'h33f) return 1;
    if (a <= 10'h3bf) return 2;
    if (a <= 10'h3ef || a >= 10'h3fe) return 3;
    return 4;
  endfunction

  initial begin
    erase_done = 1'b0;
    res_rd = 1'b0;
    res_idx = 3'h0;
    res_valid = 8'h00;
    res_word = '0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("protect", prot, 1);
    check("trim", trim, 8'h3c);
    u_host.wr(6'h2f, 8'h00);
    for (int a = 6'h33; a <= 6'h3d; a++) begin
      if (a != 6'h36) u_host.wr(a[5:0], 8'h00);
    end
    u_host.wr(6'h28, 8'ha5);
    u_host.wr(6'h29, 8'h5a);
    u_host.wr(6'h2a, 8'hf7);
    check("sel", {cap, res}, 16'ha55a);
    check("flags", flags, 4'hb);
    check("polarity", pol, 1'b1);
    chk_reg(6'h2a, 8'h53);
    chk_reg(6'h3e, 8'h3c);
    for (int l = 0; l < 2; l++) begin
      u_host.wr(6'h30, l ? 8'hfa : 8'hf5);
      chk_reg(6'h30, l ? 8'h0a : 8'h05);
      for (int i = 0; i < 12; i++) begin
        u_host.nv(nva[i], ng, nb);
        r = range_of(nva[i]);
        check("lock", {ng, nb}, (r % 2 == l && r < 4) ? 2'b01 : 2'b10);
      end
    end
    u_host.wr(6'h31, 8'h12);
    u_host.wr(6'h31, 8'h34);
    chk_reg(6'h31, 8'h12);
    u_host.wr(6'h32, 8'h00);
    u_host.wr(6'h32, 8'h56);
    chk_reg(6'h32, 8'h56);
    for (int i = 0; i < 3; i++) begin
      u_host.wr(6'h36, i == 0 ? 8'h2d : i == 1 ? 8'h59 : 8'hb8);
      check("cmd", {st, rc, er}, 3'b100 >> i);
      if (i < 2) u_host.rd(6'h2f, q);
      if (i < 2) check("cmd clear", {st, rc, er}, 3'b000);
    end
    @(posedge clk);
    #1;
    erase_done = 1'b1;
    @(posedge clk);
    #1;
    erase_done = 1'b0;
    chk_reg(6'h31, 8'h00);
    check("cmd clear", {st, rc, er}, 3'b000);
    chk_reg(6'h32, 8'h00);
    for (int k = 0; k < 8; k++) offer(k, 32'hc0de_0000 + k);
    for (int k = 0; k < 8; k++) begin
      u_host.wr(6'h2f, 8'h00);
      u_host.wr(6'h27, {k[3:0], 4'(7 - k)});
      u_host.wr(6'h2f, 8'hff);
      check("run", {run, prot}, 2'b10);
      check("if1", if1, 32'hc0de_0000 + k);
      check("if0", if0, 32'hc0de_0007 - k);
    end
    chk_reg(6'h2f, 8'h01);
    u_host.wr(6'h2f, 8'h00);
    check("protect", prot, 1);
    rres(2, 32'hc0de_0002);
    u_host.wr(6'h2a, 8'h08);
    u_host.wr(6'h2f, 8'h01);
    offer(2, 32'hbeef_0001);
    rres(2, 32'hbeef_0001);
    offer(2, 32'hbeef_0002);
    offer(2, 32'hbeef_0003);
    rres(2, 32'hbeef_0002);
    offer(2, 32'hbeef_0004);
    rres(2, 32'hbeef_0004);
    close_out();
  end
endmodule

// File: core/cdc_cfg_pkg.sv
// constants of the upper configuration bank of the converter
// assumes byte-wide serial register access, 10-bit nvram addresses
package cdc_cfg_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned NV_ADDR_W = 10;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned RES_WORDS = 8;
  localparam int unsigned SEL_W = 4;

  // register offsets
  localparam logic [5:0] OFF_PULSE_SOURCE = 6'h27;
  localparam logic [5:0] OFF_CAP_RATIO = 6'h28;
  localparam logic [5:0] OFF_RES_RATIO = 6'h29;
  // feature flags sit at index 42; 0x30 is taken by the lock register
  localparam logic [5:0] OFF_FEATURE_FLAGS = 6'h2a;
  localparam logic [5:0] OFF_RUN_CONTROL = 6'h2f;
  localparam logic [5:0] OFF_RANGE_LOCK = 6'h30;
  localparam logic [5:0] OFF_SERIAL_LOW = 6'h31;
  localparam logic [5:0] OFF_SERIAL_HIGH = 6'h32;
  localparam logic [5:0] OFF_MEMORY_CMD = 6'h36;
  localparam logic [5:0] OFF_PUMP_TRIM_LOW = 6'h3e;

  // writable bits; the rest read as zero
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_FEATURE = 8'h5b;
  localparam logic [7:0] MASK_RUN = 8'h01;
  localparam logic [7:0] MASK_LOCK = 8'h0f;

  // field positions
  localparam int unsigned PS_IF1_HI = 7;
  localparam int unsigned PS_IF1_LO = 4;
  localparam int unsigned PS_IF0_HI = 3;
  localparam int unsigned PS_IF0_LO = 0;
  localparam int unsigned FF_ALARM_SOURCE = 6;
  localparam int unsigned FF_ALARM_POLARITY = 4;
  localparam int unsigned FF_HOLD_UNTIL_READ = 3;
  localparam int unsigned FF_MEDIAN_RES = 1;
  localparam int unsigned FF_MEDIAN_CAP = 0;
  localparam int unsigned RUN_BIT_POS = 0;

  // memory command codes
  localparam logic [7:0] CMD_NONE = 8'h00;
  localparam logic [7:0] CMD_STORE = 8'h2d;
  localparam logic [7:0] CMD_RECALL = 8'h59;
  localparam logic [7:0] CMD_ERASE = 8'hb8;

  // pulse source selections above this have no result word
  localparam logic [3:0] SEL_LAST_WORD = 4'h7;

  // nvram lock range ends (inclusive); NV_R3_TAIL is where the tail of range 3 starts
  localparam logic [9:0] NV_R0_END = 10'd703;
  localparam logic [9:0] NV_R1_END = 10'd831;
  localparam logic [9:0] NV_R2_END = 10'd959;
  localparam logic [9:0] NV_R3_END = 10'd1007;
  localparam logic [9:0] NV_R3_TAIL = 10'd1022;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    MEM_IDLE = 2'b00,
    MEM_ARMED = 2'b01
  } mem_state_e;
endpackage

// File: core/cdc_config_regs_upper.sv
// upper configuration register bank of the converter
// assumes the serial interface delivers decoded byte reads and writes,
// one-cycle strobes, synchronous to i_sys_clk
`timescale 1ns/100ps
module cdc_config_regs_upper #(
  // device-specific trim loaded once after reset release; value is arbitrary
  parameter logic [7:0] PUMP_TRIM_RESET = 8'h00
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // serial interface register access
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [5:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // serial interface nvram access check
  input wire logic i_nv_req,
  input wire logic [9:0] i_nv_addr,
  output logic o_nv_granted,
  output logic o_nv_blocked,
  // nvram engine
  input wire logic i_nv_erase_done,
  output logic o_nv_store_en,
  output logic o_nv_recall_en,
  output logic o_nv_erase_en,
  // result words from the dsp and the host read path
  input wire logic [7:0] i_res_valid,
  input wire logic [7:0][31:0] i_res_word,
  input wire logic i_res_rd,
  input wire logic [2:0] i_res_idx,
  output logic [31:0] o_res_rdata,
  // firmware and front end controls
  output logic [31:0] o_pulse_if0_word,
  output logic [31:0] o_pulse_if1_word,
  output logic [7:0] o_cap_ratio_sel,
  output logic [7:0] o_res_ratio_sel,
  output logic o_alarm_source_choice,
  output logic o_alarm_polarity_choice,
  output logic o_hold_until_read,
  output logic o_median_res_en,
  output logic o_median_cap_en,
  output logic o_run_enable,
  output logic o_protect,
  output logic [7:0] o_pump_trim
);
  typedef struct packed {
    logic [7:0] pulse_source;
    logic [7:0] cap_ratio;
    logic [7:0] res_ratio;
    logic [7:0] feature_flags;
    logic [7:0] run_control;
    logic [7:0] range_lock;
    logic [7:0] serial_low;
    logic [7:0] serial_high;
    logic [7:0] memory_command;
    logic [7:0] pump_trim;
    cdc_cfg_pkg::mem_state_e mem_state;
    logic trim_loaded;
    logic [7:0] rdata;
    logic [31:0] res_rdata;
    logic nv_granted;
    logic nv_blocked;
    logic protect;
    logic store_en;
    logic recall_en;
    logic erase_en;
  } bank_s;

  bank_s state_reg;
  bank_s state_next;

  logic [7:0][31:0] held_words;
  logic [7:0] res_read;
  logic serial_activity;
  logic wr_sel;
  logic nv_locked;

  result_hold u_hold (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_hold_until_read(state_reg.feature_flags[
      cdc_cfg_pkg::FF_HOLD_UNTIL_READ]),
    .i_new_valid(i_res_valid),
    .i_new_word(i_res_word),
    .i_read(res_read),
    .o_word(held_words)
  );

  pulse_source_mux u_mux (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pulse_source(state_reg.pulse_source),
    .i_words(held_words),
    .o_pulse_if0_word(o_pulse_if0_word),
    .o_pulse_if1_word(o_pulse_if1_word)
  );

  always_comb begin
    res_read = '0;
    res_read[i_res_idx] = i_res_rd;
  end

  assign serial_activity = i_reg_wr | i_reg_rd | i_nv_req;
  assign wr_sel = i_reg_wr;

  // which lock bit covers the requested nvram address
  always_comb begin
    nv_locked = 1'b0;
    if (i_nv_addr <= cdc_cfg_pkg::NV_R0_END) begin
      nv_locked = state_reg.range_lock[0];
    end else if (i_nv_addr <= cdc_cfg_pkg::NV_R1_END) begin
      nv_locked = state_reg.range_lock[1];
    end else if (i_nv_addr <= cdc_cfg_pkg::NV_R2_END) begin
      nv_locked = state_reg.range_lock[2];
    end else if (i_nv_addr <= cdc_cfg_pkg::NV_R3_END ||
                 i_nv_addr >= cdc_cfg_pkg::NV_R3_TAIL) begin
      nv_locked = state_reg.range_lock[3];
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.nv_granted = i_nv_req & ~nv_locked;
    state_next.nv_blocked = i_nv_req & nv_locked;

    // trim byte is loaded from the strap once after reset release
    if (!state_reg.trim_loaded) begin
      state_next.pump_trim = PUMP_TRIM_RESET;
      state_next.trim_loaded = 1'b1;
    end

    // memory command lives until the following serial activity
    unique case (state_reg.mem_state)
      cdc_cfg_pkg::MEM_IDLE: begin
        state_next.memory_command = cdc_cfg_pkg::CMD_NONE;
      end
      cdc_cfg_pkg::MEM_ARMED: begin
        if (serial_activity) begin
          state_next.memory_command = cdc_cfg_pkg::CMD_NONE;
          state_next.mem_state = cdc_cfg_pkg::MEM_IDLE;
        end
      end
      default: begin
        state_next.memory_command = cdc_cfg_pkg::CMD_NONE;
        state_next.mem_state = cdc_cfg_pkg::MEM_IDLE;
      end
    endcase

    // a finished erase returns the serial number bytes to zero
    if (i_nv_erase_done) begin
      state_next.serial_low = cdc_cfg_pkg::RESET_BYTE;
      state_next.serial_high = cdc_cfg_pkg::RESET_BYTE;
    end

    if (wr_sel) begin
      unique case (i_reg_addr)
        cdc_cfg_pkg::OFF_PULSE_SOURCE: begin
          state_next.pulse_source = i_reg_wdata;
        end
        cdc_cfg_pkg::OFF_CAP_RATIO: begin
          state_next.cap_ratio = i_reg_wdata;
        end
        cdc_cfg_pkg::OFF_RES_RATIO: begin
          state_next.res_ratio = i_reg_wdata;
        end
        cdc_cfg_pkg::OFF_FEATURE_FLAGS: begin
          // internal speed bit and spare bits stay zero
          state_next.feature_flags =
            i_reg_wdata & cdc_cfg_pkg::MASK_FEATURE;
        end
        cdc_cfg_pkg::OFF_RUN_CONTROL: begin
          state_next.run_control =
            i_reg_wdata & cdc_cfg_pkg::MASK_RUN;
        end
        cdc_cfg_pkg::OFF_RANGE_LOCK: begin
          state_next.range_lock =
            i_reg_wdata & cdc_cfg_pkg::MASK_LOCK;
        end
        cdc_cfg_pkg::OFF_SERIAL_LOW: begin
          // erase in the same cycle wins so the byte ends cleared
          if (state_reg.serial_low == cdc_cfg_pkg::RESET_BYTE &&
              !i_nv_erase_done) begin
            state_next.serial_low = i_reg_wdata;
          end
        end
        cdc_cfg_pkg::OFF_SERIAL_HIGH: begin
          if (state_reg.serial_high == cdc_cfg_pkg::RESET_BYTE &&
              !i_nv_erase_done) begin
            state_next.serial_high = i_reg_wdata;
          end
        end
        cdc_cfg_pkg::OFF_MEMORY_CMD: begin
          // the command write itself is not the clearing activity
          state_next.memory_command = i_reg_wdata;
          state_next.mem_state = cdc_cfg_pkg::MEM_ARMED;
        end
        cdc_cfg_pkg::OFF_PUMP_TRIM_LOW: begin
          state_next.pump_trim = i_reg_wdata;
        end
        default: begin
          // internal and unmapped registers ignore writes
        end
      endcase
    end

    state_next.rdata = cdc_cfg_pkg::RESET_BYTE;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        cdc_cfg_pkg::OFF_PULSE_SOURCE: begin
          state_next.rdata = state_reg.pulse_source;
        end
        cdc_cfg_pkg::OFF_CAP_RATIO: begin
          state_next.rdata = state_reg.cap_ratio;
        end
        cdc_cfg_pkg::OFF_RES_RATIO: begin
          state_next.rdata = state_reg.res_ratio;
        end
        cdc_cfg_pkg::OFF_FEATURE_FLAGS: begin
          state_next.rdata = state_reg.feature_flags;
        end
        cdc_cfg_pkg::OFF_RUN_CONTROL: begin
          state_next.rdata = state_reg.run_control;
        end
        cdc_cfg_pkg::OFF_RANGE_LOCK: begin
          state_next.rdata = state_reg.range_lock;
        end
        cdc_cfg_pkg::OFF_SERIAL_LOW: begin
          state_next.rdata = state_reg.serial_low;
        end
        cdc_cfg_pkg::OFF_SERIAL_HIGH: begin
          state_next.rdata = state_reg.serial_high;
        end
        cdc_cfg_pkg::OFF_MEMORY_CMD: begin
          state_next.rdata = state_reg.memory_command;
        end
        cdc_cfg_pkg::OFF_PUMP_TRIM_LOW: begin
          state_next.rdata = state_reg.pump_trim;
        end
        default: begin
          state_next.rdata = cdc_cfg_pkg::RESET_BYTE;
        end
      endcase
    end

    if (i_res_rd) begin
      state_next.res_rdata = held_words[i_res_idx];
    end

    // protection is the inverse of the run bit, in step with the stored value
    state_next.protect =
      ~state_next.run_control[cdc_cfg_pkg::RUN_BIT_POS];

    // enables registered so they stand exactly as long as the command byte
    state_next.store_en =
      (state_next.memory_command == cdc_cfg_pkg::CMD_STORE);
    state_next.recall_en =
      (state_next.memory_command == cdc_cfg_pkg::CMD_RECALL);
    state_next.erase_en =
      (state_next.memory_command == cdc_cfg_pkg::CMD_ERASE);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
      state_reg.mem_state <= cdc_cfg_pkg::MEM_IDLE;
      state_reg.protect <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_reg_rdata = state_reg.rdata;
  assign o_res_rdata = state_reg.res_rdata;
  assign o_nv_granted = state_reg.nv_granted;
  assign o_nv_blocked = state_reg.nv_blocked;
  assign o_nv_store_en = state_reg.store_en;
  assign o_nv_recall_en = state_reg.recall_en;
  assign o_nv_erase_en = state_reg.erase_en;
  assign o_cap_ratio_sel = state_reg.cap_ratio;
  assign o_res_ratio_sel = state_reg.res_ratio;
  assign o_alarm_source_choice =
    state_reg.feature_flags[cdc_cfg_pkg::FF_ALARM_SOURCE];
  assign o_alarm_polarity_choice =
    state_reg.feature_flags[cdc_cfg_pkg::FF_ALARM_POLARITY];
  assign o_hold_until_read =
    state_reg.feature_flags[cdc_cfg_pkg::FF_HOLD_UNTIL_READ];
  assign o_median_res_en =
    state_reg.feature_flags[cdc_cfg_pkg::FF_MEDIAN_RES];
  assign o_median_cap_en =
    state_reg.feature_flags[cdc_cfg_pkg::FF_MEDIAN_CAP];
  assign o_run_enable =
    state_reg.run_control[cdc_cfg_pkg::RUN_BIT_POS];
  assign o_protect = state_reg.protect;
  assign o_pump_trim = state_reg.pump_trim;
endmodule

// File: core/pulse_source_mux.sv
// picks the result words that feed the two pulse output interfaces
// assumes result words are stable flops; output is registered
`timescale 1ns/100ps
module pulse_source_mux (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_pulse_source,
  input wire logic [7:0][31:0] i_words,
  output logic [31:0] o_pulse_if0_word,
  output logic [31:0] o_pulse_if1_word
);
  typedef struct packed {
    logic [31:0] if0;
    logic [31:0] if1;
  } mux_s;

  mux_s state_reg;
  mux_s state_next;

  // codes 8..15 name no word; feed zero rather than alias
  function automatic logic [31:0] pick(input logic [3:0] sel,
                                       input logic [7:0][31:0] w);
    logic [31:0] r;
    r = cdc_cfg_pkg::RESET_WORD;
    if (sel <= cdc_cfg_pkg::SEL_LAST_WORD) begin
      r = w[sel[2:0]];
    end
    return r;
  endfunction

  always_comb begin
    state_next.if0 = pick(i_pulse_source[cdc_cfg_pkg::PS_IF0_HI:
                                         cdc_cfg_pkg::PS_IF0_LO],
                          i_words);
    state_next.if1 = pick(i_pulse_source[cdc_cfg_pkg::PS_IF1_HI:
                                         cdc_cfg_pkg::PS_IF1_LO],
                          i_words);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_pulse_if0_word = state_reg.if0;
  assign o_pulse_if1_word = state_reg.if1;
endmodule

// File: core/result_hold.sv
// result words with optional hold until the previous value was read
// assumes one-cycle update and read strobes from the dsp and read path
`timescale 1ns/100ps
module result_hold (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_hold_until_read,
  input wire logic [7:0] i_new_valid,
  input wire logic [7:0][31:0] i_new_word,
  input wire logic [7:0] i_read,
  output logic [7:0][31:0] o_word
);
  typedef struct packed {
    logic [31:0] word;
    logic unread;
  } entry_s;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_entry
      entry_s state_reg;
      entry_s state_next;
      always_comb begin
        state_next = state_reg;
        if (i_read[g]) begin
          state_next.unread = 1'b0;
        end
        // a value not yet read blocks the update while holding
        if (i_new_valid[g] && !(i_hold_until_read && state_reg.unread)) begin
          state_next.word = i_new_word[g];
          state_next.unread = 1'b1;
        end
      end
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          state_reg <= '0;
        end else begin
          state_reg <= state_next;
        end
      end
      assign o_word[g] = state_reg.word;
    end
  endgenerate
endmodule
